//--- asp_pkg.sv
// Shared constants and types for the asynchronous serial port
package asp_pkg;

    // Printed register indices; byte address is four times the index
    localparam logic [9:0] CTRL_INDEX = 10'h098;
    localparam logic [9:0] DATA_INDEX = 10'h099;
    localparam logic [9:0] CONFIG_INDEX = 10'h09A;
    localparam logic [11:0] CTRL_ADDR = {CTRL_INDEX, 2'b00};
    localparam logic [11:0] DATA_ADDR = {DATA_INDEX, 2'b00};
    localparam logic [11:0] CONFIG_ADDR = {CONFIG_INDEX, 2'b00};

    // Control register field positions
    localparam int CTRL_FORMAT_BIT = 7;
    localparam int CTRL_UNUSED_BIT = 6;
    localparam int CTRL_CHECK_BIT = 5;
    localparam int CTRL_RXON_BIT = 4;
    localparam int CTRL_TX9_BIT = 3;
    localparam int CTRL_RX9_BIT = 2;
    localparam int CTRL_TXDONE_BIT = 1;
    localparam int CTRL_RXDONE_BIT = 0;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    // Config register field positions
    localparam int CFG_RELOAD_LSB = 0;
    localparam int CFG_IRQ_EN_BIT = 8;
    localparam int CFG_RUN_BIT = 9;
    localparam logic [7:0] RELOAD_RESET = 8'h00;

    // Timer wraps from this count back to the reload value
    localparam logic [7:0] TIMER_TOP = 8'hFF;
    localparam logic [3:0] DATA_BITS = 4'h8;
    localparam logic [7:0] DATA_RESET = 8'h00;

    typedef struct packed {
        logic frame_format_select;
        logic unused;
        logic check_enable_bit;
        logic receiver_on_bit;
        logic tx_ninth_bit;
        logic rx_ninth_bit;
        logic tx_done_flag;
        logic rx_done_flag;
    } asp_ctrl_t;

    typedef struct packed {
        logic run;
        logic irq_en;
        logic [7:0] reload;
    } asp_cfg_t;

    typedef enum {
        ASP_TX_IDLE, ASP_TX_START, ASP_TX_DATA, ASP_TX_NINTH, ASP_TX_STOP
    } asp_tx_state_t;

    typedef enum {
        ASP_RX_IDLE, ASP_RX_START, ASP_RX_DATA, ASP_RX_NINTH, ASP_RX_STOP
    } asp_rx_state_t;

endpackage : asp_pkg

//--- asp_baud_timer.sv
// Eight-bit auto-reload baud timer with forced reload
`timescale 1ns/1ps
module asp_baud_timer (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control
    input wire logic tick,
    input wire logic run,
    input wire logic force_reload,
    input wire logic [7:0] reload,
    // Overflow pulse
    output logic ovf
);
    logic [7:0] count_q;
    logic ovf_q;

    // Period is 256 minus the reload value in timer ticks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_q <= 8'h00;
        end else if (force_reload) begin
            count_q <= reload;
        end else if (run && tick) begin
            if (count_q == asp_pkg::TIMER_TOP) begin
                count_q <= reload;
            end else begin
                count_q <= count_q + 8'h01;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ovf_q <= 1'b0;
        end else begin
            ovf_q <= run && tick && !force_reload
                && (count_q == asp_pkg::TIMER_TOP);
        end
    end

    assign ovf = ovf_q;

endmodule : asp_baud_timer

//--- asp_serial_port.sv
// Full-duplex serial port with 8-bit and 9-bit frames and APB registers
//
// Overview of operation
// - Bit rate is timer overflow rate halved; period is 256 minus reload.
// - Receive timer is a private copy, reloaded at each start edge.
// - Data reads return receive latch; writes load transmit shift register.
// - Control bit 7 clear selects 8-bit frames, set selects 9-bit.
// - 8-bit frame: start, eight data bits LSB first, one stop.
// - 8-bit mode stores received stop level into received ninth bit.
// - Writing the data buffer starts a transmit frame.
// - Transmit-done flag sets at the start of the stop bit.
// - Receiver accepts frames only while receive enable is set.
// - 8-bit accept needs done flag clear and, if checking, stop high.
// - On overrun the earlier byte stays; later frame is discarded.
// - Rejected frame leaves buffer, ninth bit and done flag untouched.
// - Interrupt request follows either done flag when enabled.
// - 9-bit frame: start, eight data LSB first, ninth bit, stop.
// - Transmitted ninth bit comes from software field, only in 9-bit mode.
// - 9-bit mode stores received ninth bit and ignores stop level.
// - 9-bit accept needs done flag clear and, if checking, ninth high.
// - Receive-done flag sets at stop sampling when a byte is accepted.
// - Hardware never clears the done flags; only software writes do.
// - Control bit 6 always reads one and ignores writes.
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps
module asp_serial_port (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Baud timer clock enable, one pulse per timer tick
    input wire logic baud_timer_clock,
    // Serial pins
    output logic txd,
    input wire logic rxd,
    // Interrupt request
    output logic irq
);
    asp_pkg::asp_ctrl_t ctrl_q;
    asp_pkg::asp_cfg_t cfg_q;
    logic [7:0] rx_buf_q;
    logic [7:0] tx_shift_q;
    logic tx_pend_q;
    logic tx_half_q;
    logic tx_ovf;
    logic tx_bit_tick;
    logic [3:0] tx_cnt_q;
    logic txd_q;
    asp_pkg::asp_tx_state_t tx_state_q;
    logic rx_prev_q;
    logic rx_fall;
    logic rx_force;
    logic rx_ovf;
    logic rx_half_q;
    logic rx_sample;
    logic [7:0] rx_shift_q;
    logic [3:0] rx_cnt_q;
    logic rx_ninth_q;
    asp_pkg::asp_rx_state_t rx_state_q;
    logic rx_accept;
    logic rx_stop_sample;
    logic tx_done_set;
    logic access;
    logic wr_ctrl;
    logic wr_data;
    logic wr_cfg;
    logic mapped;

    function automatic logic addr_is(input logic [11:0] a,
                                     input logic [11:0] r);
        return a == r;
    endfunction : addr_is

    // APB decode: zero wait states, error on unmapped addresses
    assign access = psel && penable;
    assign mapped = addr_is(paddr, asp_pkg::CTRL_ADDR)
        || addr_is(paddr, asp_pkg::DATA_ADDR)
        || addr_is(paddr, asp_pkg::CONFIG_ADDR);
    assign wr_ctrl = access && pwrite && addr_is(paddr, asp_pkg::CTRL_ADDR);
    assign wr_data = access && pwrite && addr_is(paddr, asp_pkg::DATA_ADDR);
    assign wr_cfg = access && pwrite && addr_is(paddr, asp_pkg::CONFIG_ADDR);
    assign pready = 1'b1;
    assign pslverr = access && !mapped;

    always_comb begin
        prdata = 32'h0000_0000;
        if (addr_is(paddr, asp_pkg::CTRL_ADDR)) begin
            prdata[7:0] = ctrl_q;
            prdata[asp_pkg::CTRL_UNUSED_BIT] = 1'b1;
        end else if (addr_is(paddr, asp_pkg::DATA_ADDR)) begin
            prdata[7:0] = rx_buf_q;
        end else if (addr_is(paddr, asp_pkg::CONFIG_ADDR)) begin
            prdata[9:0] = cfg_q;
        end
    end

    // Software-owned control fields; bit 6 is never stored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q.frame_format_select <= 1'b0;
            ctrl_q.unused <= 1'b0;
            ctrl_q.check_enable_bit <= 1'b0;
            ctrl_q.receiver_on_bit <= 1'b0;
            ctrl_q.tx_ninth_bit <= 1'b0;
        end else if (wr_ctrl) begin
            ctrl_q.frame_format_select <= pwdata[asp_pkg::CTRL_FORMAT_BIT];
            ctrl_q.check_enable_bit <= pwdata[asp_pkg::CTRL_CHECK_BIT];
            ctrl_q.receiver_on_bit <= pwdata[asp_pkg::CTRL_RXON_BIT];
            ctrl_q.tx_ninth_bit <= pwdata[asp_pkg::CTRL_TX9_BIT];
        end
    end

    // Received ninth bit: hardware load on accept wins over software
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q.rx_ninth_bit <= 1'b0;
        end else if (rx_accept) begin
            ctrl_q.rx_ninth_bit <= ctrl_q.frame_format_select
                ? rx_ninth_q : rxd;
        end else if (wr_ctrl) begin
            ctrl_q.rx_ninth_bit <= pwdata[asp_pkg::CTRL_RX9_BIT];
        end
    end

    // Done flags: a hardware set in the same cycle as a clear wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q.tx_done_flag <= 1'b0;
            ctrl_q.rx_done_flag <= 1'b0;
        end else begin
            if (tx_done_set) begin
                ctrl_q.tx_done_flag <= 1'b1;
            end else if (wr_ctrl) begin
                ctrl_q.tx_done_flag <= pwdata[asp_pkg::CTRL_TXDONE_BIT];
            end
            if (rx_accept) begin
                ctrl_q.rx_done_flag <= 1'b1;
            end else if (wr_ctrl) begin
                ctrl_q.rx_done_flag <= pwdata[asp_pkg::CTRL_RXDONE_BIT];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q.reload <= asp_pkg::RELOAD_RESET;
            cfg_q.irq_en <= 1'b0;
            cfg_q.run <= 1'b0;
        end else if (wr_cfg) begin
            cfg_q.reload <= pwdata[asp_pkg::CFG_RELOAD_LSB +: 8];
            cfg_q.irq_en <= pwdata[asp_pkg::CFG_IRQ_EN_BIT];
            cfg_q.run <= pwdata[asp_pkg::CFG_RUN_BIT];
        end
    end

    assign irq = cfg_q.irq_en
        && (ctrl_q.tx_done_flag || ctrl_q.rx_done_flag);

    // Transmit bit timer; every second overflow ends a bit
    asp_baud_timer u_tx_timer (
        .pclk(pclk),
        .presetn(presetn),
        .tick(baud_timer_clock),
        .run(cfg_q.run),
        .force_reload(1'b0),
        .reload(cfg_q.reload),
        .ovf(tx_ovf)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_half_q <= 1'b0;
        end else if (tx_ovf) begin
            tx_half_q <= !tx_half_q;
        end
    end

    assign tx_bit_tick = tx_ovf && tx_half_q;

    // A write while a frame is in flight is dropped so the line stays sane
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_pend_q <= 1'b0;
        end else if (wr_data && tx_state_q == asp_pkg::ASP_TX_IDLE
                     && !tx_pend_q) begin
            tx_pend_q <= 1'b1;
        end else if (tx_bit_tick && tx_state_q == asp_pkg::ASP_TX_IDLE) begin
            tx_pend_q <= 1'b0;
        end
    end

    assign tx_done_set = tx_bit_tick
        && ((tx_state_q == asp_pkg::ASP_TX_DATA
             && tx_cnt_q == asp_pkg::DATA_BITS - 4'h1
             && !ctrl_q.frame_format_select)
            || tx_state_q == asp_pkg::ASP_TX_NINTH);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_state_q <= asp_pkg::ASP_TX_IDLE;
            tx_shift_q <= asp_pkg::DATA_RESET;
            tx_cnt_q <= 4'h0;
            txd_q <= 1'b1;
        end else begin
            case (tx_state_q)
                asp_pkg::ASP_TX_IDLE: begin
                    txd_q <= 1'b1;
                    if (wr_data && !tx_pend_q) begin
                        tx_shift_q <= pwdata[7:0];
                    end
                    if (tx_bit_tick && tx_pend_q) begin
                        txd_q <= 1'b0;
                        tx_cnt_q <= 4'h0;
                        tx_state_q <= asp_pkg::ASP_TX_START;
                    end
                end
                asp_pkg::ASP_TX_START: begin
                    if (tx_bit_tick) begin
                        txd_q <= tx_shift_q[0];
                        tx_shift_q <= {1'b0, tx_shift_q[7:1]};
                        tx_state_q <= asp_pkg::ASP_TX_DATA;
                    end
                end
                asp_pkg::ASP_TX_DATA: begin
                    if (tx_bit_tick) begin
                        if (tx_cnt_q == asp_pkg::DATA_BITS - 4'h1) begin
                            if (ctrl_q.frame_format_select) begin
                                txd_q <= ctrl_q.tx_ninth_bit;
                                tx_state_q <= asp_pkg::ASP_TX_NINTH;
                            end else begin
                                txd_q <= 1'b1;
                                tx_state_q <= asp_pkg::ASP_TX_STOP;
                            end
                        end else begin
                            txd_q <= tx_shift_q[0];
                            tx_shift_q <= {1'b0, tx_shift_q[7:1]};
                            tx_cnt_q <= tx_cnt_q + 4'h1;
                        end
                    end
                end
                asp_pkg::ASP_TX_NINTH: begin
                    if (tx_bit_tick) begin
                        txd_q <= 1'b1;
                        tx_state_q <= asp_pkg::ASP_TX_STOP;
                    end
                end
                asp_pkg::ASP_TX_STOP: begin
                    if (tx_bit_tick) begin
                        tx_state_q <= asp_pkg::ASP_TX_IDLE;
                    end
                end
                default: begin
                    txd_q <= 1'b1;
                    tx_state_q <= asp_pkg::ASP_TX_IDLE;
                end
            endcase
        end
    end

    assign txd = txd_q;

    // Receive side: falling edge restarts a private timer copy
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_prev_q <= 1'b1;
        end else begin
            rx_prev_q <= rxd;
        end
    end

    assign rx_fall = rx_prev_q && !rxd;
    assign rx_force = rx_fall && ctrl_q.receiver_on_bit
        && rx_state_q == asp_pkg::ASP_RX_IDLE;

    asp_baud_timer u_rx_timer (
        .pclk(pclk),
        .presetn(presetn),
        .tick(baud_timer_clock),
        .run(cfg_q.run),
        .force_reload(rx_force),
        .reload(cfg_q.reload),
        .ovf(rx_ovf)
    );

    // First overflow after reload lands mid start bit, then every second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_half_q <= 1'b0;
        end else if (rx_force) begin
            rx_half_q <= 1'b0;
        end else if (rx_ovf) begin
            rx_half_q <= !rx_half_q;
        end
    end

    assign rx_sample = rx_ovf && !rx_half_q;
    assign rx_stop_sample = rx_sample && rx_state_q == asp_pkg::ASP_RX_STOP;
    // Acceptance; failing it drops the frame and keeps the old byte
    assign rx_accept = rx_stop_sample && !ctrl_q.rx_done_flag
        && (!ctrl_q.check_enable_bit
            || (ctrl_q.frame_format_select ? rx_ninth_q : rxd));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_buf_q <= asp_pkg::DATA_RESET;
        end else if (rx_accept) begin
            rx_buf_q <= rx_shift_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_state_q <= asp_pkg::ASP_RX_IDLE;
            rx_shift_q <= asp_pkg::DATA_RESET;
            rx_cnt_q <= 4'h0;
            rx_ninth_q <= 1'b0;
        end else if (!ctrl_q.receiver_on_bit) begin
            rx_state_q <= asp_pkg::ASP_RX_IDLE;
        end else begin
            case (rx_state_q)
                asp_pkg::ASP_RX_IDLE: begin
                    if (rx_force) begin
                        rx_cnt_q <= 4'h0;
                        rx_state_q <= asp_pkg::ASP_RX_START;
                    end
                end
                asp_pkg::ASP_RX_START: begin
                    if (rx_sample) begin
                        // A glitch that is high again mid bit is no start
                        rx_state_q <= rxd ? asp_pkg::ASP_RX_IDLE
                                          : asp_pkg::ASP_RX_DATA;
                    end
                end
                asp_pkg::ASP_RX_DATA: begin
                    if (rx_sample) begin
                        rx_shift_q <= {rxd, rx_shift_q[7:1]};
                        rx_cnt_q <= rx_cnt_q + 4'h1;
                        if (rx_cnt_q == asp_pkg::DATA_BITS - 4'h1) begin
                            rx_state_q <= ctrl_q.frame_format_select
                                ? asp_pkg::ASP_RX_NINTH
                                : asp_pkg::ASP_RX_STOP;
                        end
                    end
                end
                asp_pkg::ASP_RX_NINTH: begin
                    if (rx_sample) begin
                        rx_ninth_q <= rxd;
                        rx_state_q <= asp_pkg::ASP_RX_STOP;
                    end
                end
                asp_pkg::ASP_RX_STOP: begin
                    if (rx_sample) begin
                        rx_state_q <= asp_pkg::ASP_RX_IDLE;
                    end
                end
                default: begin
                    rx_state_q <= asp_pkg::ASP_RX_IDLE;
                end
            endcase
        end
    end

    // Checks
    a_irq_follows_flags: assert property (@(posedge pclk) disable iff (!presetn)
        irq == (cfg_q.irq_en && (ctrl_q.tx_done_flag || ctrl_q.rx_done_flag)))
        else $error("irq does not follow done flags");
    a_unused_reads_one: assert property (@(posedge pclk) disable iff (!presetn)
        addr_is(paddr, asp_pkg::CTRL_ADDR) |-> prdata[6])
        else $error("control bit 6 not read as one");
    a_txdone_at_stop: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(ctrl_q.tx_done_flag) |-> tx_state_q == asp_pkg::ASP_TX_STOP
        && txd)
        else $error("tx done not at stop bit start");
    a_rxdone_accept: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(ctrl_q.rx_done_flag) |-> $past(rx_stop_sample))
        else $error("rx done set away from stop sample");
    a_flags_no_hw_clear: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(ctrl_q.rx_done_flag) || $fell(ctrl_q.tx_done_flag)
        |-> $past(wr_ctrl))
        else $error("done flag cleared without write");
    a_overrun_keeps: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_q.rx_done_flag && !wr_ctrl |=> $stable(rx_buf_q))
        else $error("buffer overwritten during overrun");
    a_reject_stable: assert property (@(posedge pclk) disable iff (!presetn)
        rx_stop_sample && ctrl_q.check_enable_bit && !ctrl_q.frame_format_select
        && !rxd && !wr_ctrl |=> $stable(ctrl_q.rx_ninth_bit)
        && !$rose(ctrl_q.rx_done_flag))
        else $error("rejected frame changed state");
    a_ninth_check: assert property (@(posedge pclk) disable iff (!presetn)
        rx_accept && ctrl_q.frame_format_select |=> ctrl_q.rx_ninth_bit
        == $past(rx_ninth_q))
        else $error("ninth bit not stored");
    a_start_bit_low: assert property (@(posedge pclk) disable iff (!presetn)
        tx_state_q == asp_pkg::ASP_TX_START |-> !txd)
        else $error("start bit not low");
    a_rx_off_idle: assert property (@(posedge pclk) disable iff (!presetn)
        !ctrl_q.receiver_on_bit |=> rx_state_q == asp_pkg::ASP_RX_IDLE)
        else $error("receiver active while disabled");

    c_tx_frame: cover property (@(posedge pclk) disable iff (!presetn)
        $rose(ctrl_q.tx_done_flag));
    c_rx_accept: cover property (@(posedge pclk) disable iff (!presetn)
        rx_accept);
    c_rx_overrun: cover property (@(posedge pclk) disable iff (!presetn)
        rx_stop_sample && ctrl_q.rx_done_flag);
    c_nine_bit_rx: cover property (@(posedge pclk) disable iff (!presetn)
        rx_accept && ctrl_q.frame_format_select);

endmodule : asp_serial_port

//--- asp_remote.sv
// Behavioural remote serial device facing the port's pins
`timescale 1ns/1ps
module asp_remote #(
    parameter int BIT = 8
) (
    // Clock
    input wire logic pclk,
    // Serial pins
    input wire logic txd,
    output logic rxd
);
    logic nine = 1'b0;
    logic [9:0] got = 10'h000;
    int frames = 0;

    initial rxd = 1'b1;

    // Samples mid-bit from the falling start edge, like a real receiver
    initial forever begin
        @(negedge txd);
        repeat (BIT / 2) @(posedge pclk);
        for (int i = 0; i < (nine ? 10 : 9); i++) begin
            repeat (BIT) @(posedge pclk);
            got = {txd, got[9:1]};
        end
        if (!nine) begin
            got = {1'b0, got[9:1]};
        end
        frames++;
    end

    // Frame out LSB first; b9 only goes on the line in 9-bit frames
    task send(input logic [7:0] d, input logic b9, input logic stop);
        logic [10:0] f;
        f = nine ? {stop, b9, d, 1'b0} : {1'b1, stop, d, 1'b0};
        for (int i = 0; i < (nine ? 11 : 10); i++) begin
            rxd <= f[i];
            repeat (BIT) @(posedge pclk);
        end
        rxd <= 1'b1;
        repeat (BIT) @(posedge pclk);
    endtask : send
endmodule : asp_remote

//--- testbench.sv
// Self-checking bench for the serial port over APB and its serial pins
`timescale 1ns/1ps
module testbench;
    localparam logic [11:0] CA = asp_pkg::CTRL_ADDR;
    localparam logic [11:0] DA = asp_pkg::DATA_ADDR;
    localparam logic [11:0] GA = asp_pkg::CONFIG_ADDR;
    logic pclk, presetn, psel, penable, pwrite;
    logic baud_tick = 1'b0;
    logic pready, pslverr, txd, rxd, irq, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    int mismatches = 0;
    int n_tests = 0;
    int f;

    asp_serial_port u_asp_serial_port (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .baud_timer_clock(baud_tick),
        .txd(txd), .rxd(rxd), .irq(irq)
    );
    asp_remote #(.BIT(8)) u_asp_remote (.pclk(pclk), .txd(txd), .rxd(rxd));

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    // Tick every other cycle: reload 0xFE gives 8 clocks per bit
    always @(posedge pclk) begin
        baud_tick <= ~baud_tick;
    end

    task summarize;
        $display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
        if (mismatches == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : summarize

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Answer is taken at the same rising edge that samples pready high
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        logic ok;
        ok = 1'b0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (int n = 0; n < 16 && ok !== 1'b1; n++) begin
            @(posedge pclk);
            rd = prdata;
            err = pslverr;
            ok = pready;
        end
        if (ok !== 1'b1) begin
            mismatches++;
            summarize();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task rdx(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask : rdx

    // First frame waits for the free-running timer to climb from zero
    task wait_frame;
        for (int n = 0; n < 1000 && u_asp_remote.frames == f; n++)
            @(posedge pclk);
        if (u_asp_remote.frames == f) begin
            mismatches++;
            summarize();
        end
    endtask : wait_frame

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdx(CA, 32'h40);
        apb(1'b1, CA, 32'h08);
        rdx(CA, 32'h48);
        apb(1'b0, 12'hFFC, 32'h0);
        chk({31'h0, err}, 32'h1);
        apb(1'b1, GA, 32'h3FE);
        apb(1'b1, CA, 32'h08);
        f = u_asp_remote.frames;
        apb(1'b1, DA, 32'hA5);
        wait_frame();
        chk({22'h0, u_asp_remote.got}, 32'h1A5);
        rdx(CA, 32'h4A);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, CA, 32'h88);
        chk({31'h0, irq}, 32'h0);
        u_asp_remote.nine = 1'b1;
        f = u_asp_remote.frames;
        apb(1'b1, DA, 32'h3C);
        wait_frame();
        chk({22'h0, u_asp_remote.got}, 32'h33C);
        u_asp_remote.nine = 1'b0;
        apb(1'b1, CA, 32'h10);
        u_asp_remote.send(8'h5A, 1'b0, 1'b1);
        rdx(DA, 32'h5A);
        rdx(CA, 32'h55);
        u_asp_remote.send(8'h11, 1'b0, 1'b1);
        rdx(DA, 32'h5A);
        apb(1'b1, CA, 32'h30);
        u_asp_remote.send(8'h66, 1'b0, 1'b0);
        rdx(CA, 32'h70);
        apb(1'b1, CA, 32'h00);
        u_asp_remote.send(8'h22, 1'b0, 1'b1);
        rdx(CA, 32'h40);
        rdx(DA, 32'h5A);
        u_asp_remote.nine = 1'b1;
        apb(1'b1, CA, 32'hB0);
        u_asp_remote.send(8'h33, 1'b0, 1'b1);
        rdx(CA, 32'hF0);
        u_asp_remote.send(8'h44, 1'b1, 1'b0);
        rdx(DA, 32'h44);
        rdx(CA, 32'hF5);
        summarize();
    end
endmodule : testbench
